/* File: hw/usb_pkg.sv */
// Package for the setup buffer and function address block.
// Assumes an 8-bit MCU data bus with 16-bit byte addresses on one clock.
package usb_pkg;
  localparam logic [15:0] SETUP_BASE_ADDR = 16'hFF28;
  localparam logic [15:0] SETUP_LAST_ADDR = 16'hFF2F;
  localparam logic [15:0] REG_SPACE_LO = 16'hFFB0;
  localparam logic [15:0] REG_SPACE_HI = 16'hFFFF;
  localparam logic [15:0] STATUS_ADDR = 16'hFFFE;
  localparam logic [15:0] FADDR_ADDR = 16'hFFFF;
  localparam logic [15:0] VECTOR_ADDR = 16'hFFB2;
  localparam int SETUP_BYTES = 8;
  localparam int SETUP_FLAG_BIT = 2;
  localparam logic [6:0] FADDR_RESET = 7'h00;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [2:0] IDX_ZERO = 3'h0;
  localparam logic [2:0] IDX_LAST = 3'h7;
  typedef enum logic [1:0] {
    USB_RX_IDLE,
    USB_RX_FILL,
    USB_RX_WAIT
  } usb_rx_state_t;
endpackage

/* File: hw/usb_setup_if.sv */
// Interface between the register block and the setup packet collector.
// Assumes both ends run on the same clock.
interface usb_setup_if;
  logic commit;
  logic [63:0] packet;
  modport collector (output commit, output packet);
  modport regs (input commit, input packet);
endinterface

/* File: hw/usb_setup_collect.sv */
// Collects setup data bytes from the serial engine into a staging area.
// Assumes bytes arrive in wire order, first byte the request type.
module usb_setup_collect (
  // Clock and control
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic bus_reset,
  // Serial engine byte stream
  input wire logic sie_setup_start,
  input wire logic sie_byte_valid,
  input wire logic [7:0] sie_byte,
  input wire logic sie_setup_ok,
  input wire logic sie_setup_fail,
  // Toward registers
  usb_setup_if.collector setup
);
  logic [7:0] stage_ff [usb_pkg::SETUP_BYTES];
  logic [7:0] nxt_stage [usb_pkg::SETUP_BYTES];
  logic [2:0] idx_ff, nxt_idx;
  logic full_ff, nxt_full;
  logic commit_ff, nxt_commit;
  usb_pkg::usb_rx_state_t state_ff, nxt_state;

  always_comb begin
    nxt_stage = stage_ff;
    nxt_idx = idx_ff;
    nxt_full = full_ff;
    nxt_state = state_ff;
    nxt_commit = 1'b0;
    if (bus_reset) begin
      nxt_state = usb_pkg::USB_RX_IDLE;
    end else if (sie_setup_start) begin
      // A start in any state restarts, so a torn packet never mixes into the next
      nxt_state = usb_pkg::USB_RX_FILL;
      nxt_idx = usb_pkg::IDX_ZERO;
      nxt_full = 1'b0;
    end else begin
      unique case (state_ff)
        usb_pkg::USB_RX_IDLE: begin
          nxt_state = usb_pkg::USB_RX_IDLE;
        end
        usb_pkg::USB_RX_FILL: begin
          // An early end or a failure drops the partial packet
          if (sie_setup_fail || sie_setup_ok) begin
            nxt_state = usb_pkg::USB_RX_IDLE;
          end else if (sie_byte_valid) begin
            nxt_stage[idx_ff] = sie_byte;
            nxt_idx = idx_ff + 3'h1;
            if (idx_ff == usb_pkg::IDX_LAST) begin
              nxt_full = 1'b1;
              nxt_state = usb_pkg::USB_RX_WAIT;
            end
          end
        end
        usb_pkg::USB_RX_WAIT: begin
          // A short or failed packet never reaches the buffer
          if (sie_setup_ok && full_ff) begin
            nxt_commit = 1'b1;
          end
          if (sie_setup_ok || sie_setup_fail || sie_byte_valid) begin
            nxt_state = usb_pkg::USB_RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < usb_pkg::SETUP_BYTES; i++) begin
        stage_ff[i] <= usb_pkg::SETUP_RESET;
      end
      idx_ff <= usb_pkg::IDX_ZERO;
      full_ff <= 1'b0;
      commit_ff <= 1'b0;
      state_ff <= usb_pkg::USB_RX_IDLE;
    end else if (clk_en) begin
      stage_ff <= nxt_stage;
      idx_ff <= nxt_idx;
      full_ff <= nxt_full;
      commit_ff <= nxt_commit;
      state_ff <= nxt_state;
    end
  end

  assign setup.commit = commit_ff;
  always_comb begin
    for (int i = 0; i < usb_pkg::SETUP_BYTES; i++) begin
      setup.packet[8*i +: 8] = stage_ff[i];
    end
  end
endmodule

/* File: hw/usb_setup_regs.sv */
// Overview of operation
// - Buffer captures whole 8-byte setup packet
// - Request type FF28h, request code FF29h
// - Value field at FF2Ah and FF2Bh
// - Index field at FF2Ch and FF2Dh
// - Length field at FF2Eh and FF2Fh
// - Registers mapped from FFB0h to FFFFh
// - Function address in bits 6:0, FFFFh
// - Address clears on reset and bus reset
// - Address bit 7 reads zero
// - Setup flag bit 2 of FFFEh
//
// Setup packet buffer, status flag and function address on the MCU bus.
// Assumes a synchronous 8-bit MCU bus with one-cycle strobes; the serial
// engine signals are on the same clock, bus_reset arrives from a pin.
module usb_setup_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // USB bus reset, asynchronous
  input wire logic bus_reset_pin,
  // Serial engine
  input wire logic sie_setup_start,
  input wire logic sie_byte_valid,
  input wire logic [7:0] sie_byte,
  input wire logic sie_setup_ok,
  input wire logic sie_setup_fail,
  // MCU memory bus
  input wire logic [15:0] mcu_addr,
  input wire logic mcu_rd,
  input wire logic mcu_wr,
  input wire logic [7:0] mcu_wdata,
  output logic [7:0] mcu_rdata,
  output logic mcu_sel,
  // Status out
  output logic [6:0] device_address_field,
  output logic setup_received
);
  usb_setup_if setup_link ();
  logic rst_sync1_ff, rst_sync2_ff;
  logic [7:0] buf_ff [usb_pkg::SETUP_BYTES];
  logic [7:0] nxt_buf [usb_pkg::SETUP_BYTES];
  logic [6:0] faddr_ff, nxt_faddr;
  logic flag_ff, nxt_flag;
  logic [7:0] rdata_ff, nxt_rdata;
  logic sel_ff, nxt_sel;

  function automatic logic in_setup(input logic [15:0] a);
    return (a >= usb_pkg::SETUP_BASE_ADDR) && (a <= usb_pkg::SETUP_LAST_ADDR);
  endfunction

  function automatic logic in_regs(input logic [15:0] a);
    return (a >= usb_pkg::REG_SPACE_LO) && (a <= usb_pkg::REG_SPACE_HI);
  endfunction

  // Bus reset comes from the line state, so it is synchronised first
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else if (clk_en) begin
      rst_sync1_ff <= bus_reset_pin;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  usb_setup_collect u_collect (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .bus_reset(rst_sync2_ff),
    .sie_setup_start(sie_setup_start),
    .sie_byte_valid(sie_byte_valid),
    .sie_byte(sie_byte),
    .sie_setup_ok(sie_setup_ok),
    .sie_setup_fail(sie_setup_fail),
    .setup(setup_link.collector)
  );

  always_comb begin
    nxt_buf = buf_ff;
    nxt_faddr = faddr_ff;
    nxt_flag = flag_ff;
    nxt_rdata = 8'h00;
    nxt_sel = 1'b0;
    // Whole packet lands at once so firmware never sees a mix of two packets
    if (setup_link.commit) begin
      for (int i = 0; i < usb_pkg::SETUP_BYTES; i++) begin
        nxt_buf[i] = setup_link.packet[8*i +: 8];
      end
    end
    // Writing the vector register acknowledges the flag; a new packet wins
    if (mcu_wr && mcu_addr == usb_pkg::VECTOR_ADDR) begin
      nxt_flag = 1'b0;
    end
    if (setup_link.commit) begin
      nxt_flag = 1'b1;
    end
    if (mcu_wr && mcu_addr == usb_pkg::FADDR_ADDR) begin
      nxt_faddr = mcu_wdata[6:0];
    end
    if (rst_sync2_ff) begin
      nxt_faddr = usb_pkg::FADDR_RESET;
      nxt_flag = 1'b0;
    end
    if (mcu_rd) begin
      if (in_setup(mcu_addr)) begin
        // Low three address bits pick the byte, wire order from FF28h
        nxt_rdata = buf_ff[mcu_addr[2:0]];
        nxt_sel = 1'b1;
      end else if (mcu_addr == usb_pkg::FADDR_ADDR) begin
        nxt_rdata = {1'b0, faddr_ff};
        nxt_sel = 1'b1;
      end else if (mcu_addr == usb_pkg::STATUS_ADDR) begin
        nxt_rdata = 8'h00;
        nxt_rdata[usb_pkg::SETUP_FLAG_BIT] = flag_ff;
        nxt_sel = 1'b1;
      end else if (in_regs(mcu_addr)) begin
        // Other units own the rest of the space; this block answers zero
        nxt_sel = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < usb_pkg::SETUP_BYTES; i++) begin
        buf_ff[i] <= usb_pkg::SETUP_RESET;
      end
      faddr_ff <= usb_pkg::FADDR_RESET;
      flag_ff <= 1'b0;
      rdata_ff <= 8'h00;
      sel_ff <= 1'b0;
    end else if (clk_en) begin
      buf_ff <= nxt_buf;
      faddr_ff <= nxt_faddr;
      flag_ff <= nxt_flag;
      rdata_ff <= nxt_rdata;
      sel_ff <= nxt_sel;
    end
  end

  assign mcu_rdata = rdata_ff;
  assign mcu_sel = sel_ff;
  assign device_address_field = faddr_ff;
  assign setup_received = flag_ff;
endmodule

/* File: bench/usb_setup_sva.sv */
// Checker for the setup buffer and function address block.
// Bound to usb_setup_regs; assumes clk_en is held high.
module usb_setup_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Inputs
  input wire logic bus_reset_pin,
  input wire logic sie_setup_ok,
  input wire logic [15:0] mcu_addr,
  input wire logic mcu_rd,
  input wire logic mcu_wr,
  input wire logic [7:0] mcu_wdata,
  // Outputs
  input wire logic [7:0] mcu_rdata,
  input wire logic mcu_sel,
  input wire logic [6:0] device_address_field,
  input wire logic setup_received
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire fa_hit = mcu_addr == 16'hFFFF;
  wire clr_hit = mcu_wr && mcu_addr == 16'hFFB2;
  addr_read_a: assert property (
    mcu_rd && !mcu_wr && fa_hit |=> mcu_sel && mcu_rdata == {1'b0, $past(device_address_field)}) else $error("addr read");
  addr_write_a: assert property (
    mcu_wr && fa_hit && !$past(bus_reset_pin, 2) |=> device_address_field == 7'($past(mcu_wdata)))
    else $error("addr write");
  addr_hold_a: assert property ($changed(device_address_field) |->
    ($past(mcu_wr) && $past(fa_hit)) || $past(bus_reset_pin, 3) || $past(bus_reset_pin, 4)) else $error("addr hold");
  bus_clear_a: assert property (
    bus_reset_pin [*5] |-> device_address_field == 7'h00 && !setup_received) else $error("bus reset");
  flag_set_a: assert property ($rose(setup_received) |-> $past(sie_setup_ok, 2)) else $error("flag set");
  flag_hold_a: assert property ($fell(setup_received) |->
    $past(clr_hit) || $past(bus_reset_pin, 3) || $past(bus_reset_pin, 4)) else $error("flag hold");
  other_read_a: assert property (
    mcu_rd && !(mcu_addr inside {[16'hFF28:16'hFF2F], 16'hFFFE, 16'hFFFF}) |=> !mcu_sel && mcu_rdata == 8'h00)
    else $error("other read");
  sel_cause_a: assert property (mcu_sel |-> $past(mcu_rd)) else $error("sel cause");
  cover property ($rose(setup_received));
  cover property (bus_reset_pin [*5]);
  cover property (clr_hit);
endmodule
bind usb_setup_regs usb_setup_sva i_sva (.clock, .reset_n, .bus_reset_pin, .sie_setup_ok, .mcu_addr, .mcu_rd,
  .mcu_wr, .mcu_wdata, .mcu_rdata, .mcu_sel, .device_address_field, .setup_received);

/* File: bench/usb_sie_model.sv */
// Serial engine stand-in that hands setup packets to the block.
// Assumes the bench calls send from one process at a time.
module usb_sie_model (
  // Clock
  input wire logic clock,
  // Byte stream
  output logic sie_setup_start,
  output logic sie_byte_valid,
  output logic [7:0] sie_byte,
  output logic sie_setup_ok,
  output logic sie_setup_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {sie_setup_start, sie_byte_valid, sie_byte, sie_setup_ok, sie_setup_fail} = 12'h000;
  // Gap idles after start to mimic a slow host; idle byte lines show the inverse of the last byte
  task automatic send(input logic [63:0] pkt, input int n, input logic good, input int gap);
    @(posedge clock);
    sie_setup_start <= 1'b1;
    @(posedge clock);
    sie_setup_start <= 1'b0;
    repeat (gap) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      sie_byte_valid <= 1'b1;
      sie_byte <= pkt[i*8 +: 8];
      @(posedge clock);
    end
    sie_byte_valid <= 1'b0;
    sie_byte <= ~sie_byte;
    sie_setup_ok <= good;
    sie_setup_fail <= !good;
    @(posedge clock);
    {sie_setup_ok, sie_setup_fail} <= 2'b00;
    @(posedge clock);
  endtask
endmodule

/* File: bench/usb_setup_buffer_and_address_bench.sv */
// Self-checking bench for the setup buffer and function address block.
// MCU bus driven here; packets come from the serial engine model.
module usb_setup_buffer_and_address_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic bus_reset_pin = 1'b0;
  logic mcu_rd = 1'b0;
  logic mcu_wr = 1'b0;
  logic [15:0] mcu_addr = 16'h0000;
  logic [7:0] mcu_wdata = 8'h00;
  logic [7:0] mcu_rdata, sie_byte;
  logic [6:0] device_address_field;
  logic mcu_sel, setup_received, sie_setup_start, sie_byte_valid, sie_setup_ok, sie_setup_fail;
  int error_cnt = 0;
  int cmp_count = 0;
  localparam logic [63:0] PKT_A = 64'h0000_0000_0005_0500;
  localparam logic [63:0] PKT_B = 64'hFFEE_DDCC_BBAA_9988;
  usb_setup_regs i_dut (.clock, .reset_n, .clk_en(1'b1), .bus_reset_pin, .sie_setup_start, .sie_byte_valid,
    .sie_byte, .sie_setup_ok, .sie_setup_fail, .mcu_addr, .mcu_rd, .mcu_wr, .mcu_wdata, .mcu_rdata, .mcu_sel,
    .device_address_field, .setup_received);
  usb_sie_model i_sie (.clock, .sie_setup_start, .sie_byte_valid, .sie_byte, .sie_setup_ok, .sie_setup_fail);
  initial forever #5 clock = ~clock;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("ERROR %0t seen %h exp %h", $time, seen, exp);
      error_cnt++;
    end
  endtask
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    {mcu_rd, mcu_wr} <= {!wr, wr};
    mcu_addr <= a;
    mcu_wdata <= d;
    @(posedge clock);
    {mcu_rd, mcu_wr} <= 2'b00;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(mcu_rdata, exp);
    check({7'h00, mcu_sel}, {7'h00, a inside {[16'hFF28:16'hFF2F], 16'hFFFE, 16'hFFFF}});
  endtask
  task automatic chkbuf(input logic [63:0] p);
    for (int i = 0; i < 8; i++) rd(16'hFF28 + 16'(i), p[i*8 +: 8]);
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    rd(16'hFFFF, 8'h00);
    bus(1'b1, 16'hFFFF, 8'hFF);
    rd(16'hFFFF, 8'h7F);
    i_sie.send(PKT_A, 8, 1'b1, 0);
    rd(16'hFFFE, 8'h04);
    check({7'h00, setup_received}, 8'h01);
    chkbuf(PKT_A);
    bus(1'b1, 16'hFFFF, {1'b0, PKT_A[22:16]});
    check({1'b0, device_address_field}, 8'h05);
    bus(1'b1, 16'hFFB2, 8'h00);
    rd(16'hFFFE, 8'h00);
    i_sie.send(PKT_B, 8, 1'b0, 3);
    i_sie.send(PKT_B, 7, 1'b1, 0);
    rd(16'hFFFE, 8'h00);
    chkbuf(PKT_A);
    i_sie.send(PKT_B, 8, 1'b1, 2);
    chkbuf(PKT_B);
    bus(1'b1, 16'hFFFE, 8'h00);
    rd(16'hFFFE, 8'h04);
    rd(16'hFFB0, 8'h00);
    rd(16'hFFFD, 8'h00);
    rd(16'hFF30, 8'h00);
    @(posedge clock);
    bus_reset_pin <= 1'b1;
    repeat (6) @(posedge clock);
    bus_reset_pin <= 1'b0;
    rd(16'hFFFF, 8'h00);
    rd(16'hFFFE, 8'h00);
    check({7'h00, setup_received}, 8'h00);
    bus(1'b1, 16'hFFFF, 8'h11);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd(16'hFFFF, 8'h00);
    give_verdict;
  end
endmodule
